/* File: hdl/dpm_host_pkg.sv */
package dpm_host_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int FLAG_SEL_W = 3;
  localparam int FLAG_COUNT = 8;
  localparam logic [13:0] RIGHT_MBOX_ADDR = 14'h3FFF;
  localparam logic [13:0] LEFT_MBOX_ADDR = 14'h3FFE;

  // Plain defaults; set to the speed grade in use
  localparam int ENABLE_ACCESS_DELAY_NS = 20;
  localparam int OUTPUT_ENABLE_DELAY_NS = 12;
  localparam int MATCH_TO_WAIT_DELAY_NS = 20;
  localparam int ENABLE_TO_WAIT_DELAY_NS = 20;
  localparam int WRITE_PULSE_NS = 15;
  localparam int FLAG_RECOVERY_TIME_NS = 10;
  localparam int FLAG_WRITE_TO_READ_DELAY_NS = 10;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  localparam int SETTLE_CYC = ns_to_cyc(max2(MATCH_TO_WAIT_DELAY_NS, ENABLE_TO_WAIT_DELAY_NS));
  localparam int READ_CYC = ns_to_cyc(max2(ENABLE_ACCESS_DELAY_NS, OUTPUT_ENABLE_DELAY_NS));
  localparam int WRITE_CYC = ns_to_cyc(WRITE_PULSE_NS);
  localparam int RECOV_CYC = ns_to_cyc(max2(FLAG_RECOVERY_TIME_NS,
                                            FLAG_WRITE_TO_READ_DELAY_NS));
  localparam int TIMER_W = 8;
  localparam int POLL_LIMIT_DEFAULT = 16;

  typedef enum logic [2:0] {
    CMD_MEM_RD,
    CMD_MEM_WR,
    CMD_MBOX_POST,
    CMD_MBOX_FETCH,
    CMD_FLAG_RD,
    CMD_FLAG_TAKE,
    CMD_FLAG_GIVE
  } cmd_e;

  typedef struct packed {
    cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic granted;
  } resp_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic rw_n;
    logic flag_latch_select_n;
    logic [ADDR_W-1:0] addr;
  } pins_s;

  localparam pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1,
                                  flag_latch_select_n: 1'b1, addr: 14'h0000};

endpackage : dpm_host_pkg

/* File: hdl/dual_port_host.sv */
`timescale 1ns/1ps
// Operation
// - Memory read drives chip-enable and output-enable low, waits access delay.
// - Flag read uses flag-latch select instead of chip-enable, plus output-enable.
// - Host delays writes until wait flag has settled after match delay.
// - Flag access with chip-enable high; low three address bits pick latch.
// - Requester writes zero, deselects for recovery time, reads back, polls.
module dual_port_host
  import dpm_host_pkg::*;
#(
  parameter bit PORT_IS_LEFT = 1'b1,
  parameter int POLL_LIMIT = POLL_LIMIT_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input req_s req,
  output logic req_ready,
  output logic resp_valid,
  output resp_s resp,
  output pins_s pins,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic busy_n,
  input wire logic int_n,
  output logic mbox_irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_STROBE, ST_RECOVER} state_e;

  state_e state_ff;
  pins_s pins_ff;
  cmd_e cmd_ff;
  logic is_write_ff;
  logic is_flag_ff;
  logic take_read_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [7:0] polls_ff;
  logic ready_ff;
  logic resp_valid_ff;
  resp_s resp_ff;
  logic [DATA_W-1:0] dq_o_ff;
  logic dq_oe_ff;
  logic irq_ff;
  logic expired;
  logic tmr_load;
  logic [TIMER_W-1:0] tmr_val;
  logic accept;
  logic go;
  logic restart;

  function automatic logic [ADDR_W-1:0] mbox_addr(input cmd_e c, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] r;
    r = a;
    if (c == CMD_MBOX_POST) begin
      r = PORT_IS_LEFT ? RIGHT_MBOX_ADDR : LEFT_MBOX_ADDR;
    end else if (c == CMD_MBOX_FETCH) begin
      r = PORT_IS_LEFT ? LEFT_MBOX_ADDR : RIGHT_MBOX_ADDR;
    end
    return r;
  endfunction : mbox_addr

  function automatic logic cmd_is_flag(input cmd_e c);
    return (c == CMD_FLAG_RD) || (c == CMD_FLAG_TAKE) || (c == CMD_FLAG_GIVE);
  endfunction : cmd_is_flag

  function automatic logic cmd_is_write(input cmd_e c);
    return (c == CMD_MEM_WR) || (c == CMD_MBOX_POST) || (c == CMD_FLAG_TAKE)
           || (c == CMD_FLAG_GIVE);
  endfunction : cmd_is_write

  assign accept = (state_ff == ST_IDLE) && req_valid && ready_ff;
  assign go = (state_ff == ST_SETTLE) && expired && (is_flag_ff || busy_n);
  assign restart = (cmd_ff == CMD_FLAG_TAKE)
                   && (!take_read_ff || (rdata_ff[0] && (polls_ff < 8'(POLL_LIMIT))));

  always_comb begin
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_ff)
      ST_IDLE: begin
        tmr_load = accept;
        tmr_val = TIMER_W'(SETTLE_CYC);
      end
      ST_SETTLE: begin
        tmr_load = go;
        tmr_val = is_write_ff ? TIMER_W'(WRITE_CYC) : TIMER_W'(READ_CYC);
      end
      ST_STROBE: begin
        tmr_load = expired;
        tmr_val = TIMER_W'(RECOV_CYC);
      end
      ST_RECOVER: begin
        tmr_load = expired && restart;
        tmr_val = TIMER_W'(SETTLE_CYC);
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  span_timer #(.W(TIMER_W)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(expired)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      pins_ff <= PINS_IDLE;
      cmd_ff <= CMD_MEM_RD;
      is_write_ff <= 1'b0;
      is_flag_ff <= 1'b0;
      take_read_ff <= 1'b0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      polls_ff <= '0;
      ready_ff <= 1'b0;
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          ready_ff <= 1'b1;
          if (accept) begin
            ready_ff <= 1'b0;
            cmd_ff <= req.cmd;
            is_write_ff <= cmd_is_write(req.cmd);
            is_flag_ff <= cmd_is_flag(req.cmd);
            take_read_ff <= 1'b0;
            polls_ff <= '0;
            wdata_ff <= req.data;
            if (cmd_is_flag(req.cmd)) begin
              pins_ff.ce_n <= 1'b1;
              pins_ff.flag_latch_select_n <= 1'b0;
              pins_ff.addr <= {{(ADDR_W-FLAG_SEL_W){1'b0}}, req.addr[FLAG_SEL_W-1:0]};
            end else begin
              pins_ff.ce_n <= 1'b0;
              pins_ff.addr <= mbox_addr(req.cmd, req.addr);
            end
            state_ff <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (go) begin
            if (is_write_ff) begin
              pins_ff.rw_n <= 1'b0;
              dq_oe_ff <= 1'b1;
              // Take writes zero, give writes one
              if (cmd_ff == CMD_FLAG_TAKE) begin
                dq_o_ff <= 16'h0000;
              end else if (cmd_ff == CMD_FLAG_GIVE) begin
                dq_o_ff <= 16'h0001;
              end else begin
                dq_o_ff <= wdata_ff;
              end
            end else begin
              pins_ff.oe_n <= 1'b0;
            end
            state_ff <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (expired) begin
            if (!is_write_ff) begin
              rdata_ff <= dq_i;
            end
            pins_ff.ce_n <= 1'b1;
            pins_ff.oe_n <= 1'b1;
            pins_ff.rw_n <= 1'b1;
            pins_ff.flag_latch_select_n <= 1'b1;
            dq_oe_ff <= 1'b0;
            state_ff <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (expired) begin
            if (restart) begin
              if (take_read_ff) begin
                polls_ff <= polls_ff + 8'h01;
              end
              take_read_ff <= 1'b1;
              is_write_ff <= 1'b0;
              pins_ff.flag_latch_select_n <= 1'b0;
              state_ff <= ST_SETTLE;
            end else begin
              ready_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid_ff <= 1'b0;
      resp_ff <= '0;
    end else begin
      resp_valid_ff <= (state_ff == ST_RECOVER) && expired && !restart;
      if ((state_ff == ST_RECOVER) && expired && !restart) begin
        resp_ff.data <= rdata_ff;
        resp_ff.granted <= is_flag_ff && (cmd_ff != CMD_FLAG_GIVE) && !rdata_ff[0];
      end
    end
  end

  // Mailbox interrupt pin is active low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= !int_n;
    end
  end

  assign req_ready = ready_ff;
  assign resp_valid = resp_valid_ff;
  assign resp = resp_ff;
  assign pins = pins_ff;
  assign dq_o = dq_o_ff;
  assign dq_oe = dq_oe_ff;
  assign mbox_irq = irq_ff;

  // Checks
  localparam int SETTLE_CHK = SETTLE_CYC;
  logic [TIMER_W-1:0] desel_cnt_ff;
  logic last_flag_wr_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      desel_cnt_ff <= '0;
      last_flag_wr_ff <= 1'b0;
    end else begin
      if (!pins_ff.flag_latch_select_n) begin
        desel_cnt_ff <= '0;
        last_flag_wr_ff <= !pins_ff.rw_n;
      end else if (desel_cnt_ff != '1) begin
        desel_cnt_ff <= desel_cnt_ff + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_READ_QUAL: assert property (!pins_ff.oe_n |->
    pins_ff.rw_n && (!pins_ff.ce_n || !pins_ff.flag_latch_select_n))
    else $error("output enable without a select");
  AST_FLAG_READ: assert property ($fell(pins_ff.oe_n) && !pins_ff.flag_latch_select_n
    |-> pins_ff.ce_n && !dq_oe_ff)
    else $error("flag read with chip enable or data driven");
  AST_FLAG_CE_HIGH: assert property (!pins_ff.flag_latch_select_n |-> pins_ff.ce_n
    && (pins_ff.addr[ADDR_W-1:FLAG_SEL_W] == '0))
    else $error("flag access with chip enable low or high address bits");
  AST_WRITE_HOLDOFF: assert property ($fell(pins_ff.rw_n) && !pins_ff.ce_n |->
    $past(busy_n) && !$past(pins_ff.ce_n, SETTLE_CHK))
    else $error("write started before wait flag settled");
  AST_FLAG_RECOVERY: assert property ($fell(pins_ff.flag_latch_select_n)
    && last_flag_wr_ff |-> desel_cnt_ff >= TIMER_W'(RECOV_CYC))
    else $error("flag read back without recovery time");

  COV_MEM_WRITE: cover property ($fell(pins_ff.rw_n) && !pins_ff.ce_n);
  COV_FLAG_GRANT: cover property (resp_valid_ff && resp_ff.granted);
  COV_FLAG_POLL: cover property ((state_ff == ST_RECOVER) && expired && restart
    && take_read_ff);
  COV_BUSY_STALL: cover property ((state_ff == ST_SETTLE) && expired && !busy_n && !is_flag_ff);

endmodule : dual_port_host

/* File: hdl/span_timer.sv */
`timescale 1ns/1ps
module span_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic expired
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Holds N+1 cycles after load, never short
  assign expired = (cnt_ff == '0);
endmodule : span_timer

/* File: tb/dpm_model.sv */
`timescale 1ns/1ps
module dpm_model
  import dpm_host_pkg::*;
(
  input wire logic clk,
  input pins_s pins,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  output logic [DATA_W-1:0] dq_i,
  output logic busy_n,
  output logic int_n,
  input wire logic far_busy_n,
  input wire logic far_flag_wr,
  input wire logic [FLAG_SEL_W-1:0] far_flag_idx,
  input wire logic far_flag_bit,
  input wire logic far_mbox_wr,
  input wire logic [DATA_W-1:0] far_data
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  // Eight latches apart; 0 free, 1 near, 2 far
  logic [1:0] owner [FLAG_COUNT];
  logic [FLAG_COUNT-1:0] pend_near;
  logic [FLAG_COUNT-1:0] pend_far;
  logic [DATA_W-1:0] last;
  logic flag_q;
  logic wr_d;
  logic wb;
  logic [2:0] wi;
  wire sel_mem = !pins.ce_n && pins.flag_latch_select_n;
  wire sel_flag = pins.ce_n && !pins.flag_latch_select_n;
  wire fw = sel_flag && !pins.rw_n && dq_oe;
  assign busy_n = far_busy_n;
  initial begin
    foreach (owner[i]) owner[i] = 2'h0;
    pend_near = '0;
    pend_far = '0;
    int_n = 1'b1;
    last = '0;
    flag_q = 1'b1;
    wr_d = 1'b0;
  end
  always_comb begin
    if (!pins.oe_n && sel_mem) dq_i = mem[pins.addr];
    else if (!pins.oe_n && sel_flag) dq_i = {DATA_W{flag_q}};
    else dq_i = ~last;
  end
  always @(posedge clk) begin
    last <= dq_i;
    if (pins.oe_n) flag_q <= (owner[pins.addr[2:0]] != 2'h1);
    if (sel_mem && !pins.rw_n && busy_n) mem[pins.addr] <= dq_o;
    if (far_mbox_wr) begin
      mem[LEFT_MBOX_ADDR] <= far_data;
      int_n <= 1'b0;
    end else if (sel_mem && !pins.oe_n && pins.addr == LEFT_MBOX_ADDR && busy_n) begin
      int_n <= 1'b1;
    end
    // Bit zero only, acted at write end
    wr_d <= fw;
    if (fw) begin
      wi <= pins.addr[2:0];
      wb <= dq_o[0];
    end
    if (wr_d && !fw) begin
      if (!wb) begin
        if (owner[wi] == 2'h0) owner[wi] <= 2'h1;
        else if (owner[wi] == 2'h2) pend_near[wi] <= 1'b1;
      end else begin
        if (owner[wi] == 2'h1) begin
          owner[wi] <= pend_far[wi] ? 2'h2 : 2'h0;
          pend_far[wi] <= 1'b0;
        end
        pend_near[wi] <= 1'b0;
      end
    end
    if (far_flag_wr) begin
      if (!far_flag_bit) begin
        if (owner[far_flag_idx] == 2'h0) owner[far_flag_idx] <= 2'h2;
        else if (owner[far_flag_idx] == 2'h1) pend_far[far_flag_idx] <= 1'b1;
      end else begin
        if (owner[far_flag_idx] == 2'h2) begin
          owner[far_flag_idx] <= pend_near[far_flag_idx] ? 2'h1 : 2'h0;
          pend_near[far_flag_idx] <= 1'b0;
        end
        pend_far[far_flag_idx] <= 1'b0;
      end
    end
  end
endmodule : dpm_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import dpm_host_pkg::*;
  typedef struct {
    cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic chk;
    logic [DATA_W-1:0] exp;
    logic gr;
  } row_s;
  logic clk, sys_rst, req_valid, req_ready, resp_valid, dq_oe, busy_n, int_n, mbox_irq;
  logic far_busy_n, far_flag_wr, far_flag_bit, far_mbox_wr, done;
  logic [FLAG_SEL_W-1:0] far_flag_idx;
  logic [DATA_W-1:0] dq_i, dq_o, far_data;
  req_s req;
  resp_s resp;
  pins_s pins;
  int bad_count, compares, wr_in_busy;
  row_s rows [8];

  // Short poll limit keeps a losing take brief
  dual_port_host #(.PORT_IS_LEFT(1'b1), .POLL_LIMIT(4)) dual_port_host_inst (
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp(resp), .pins(pins), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .busy_n(busy_n), .int_n(int_n), .mbox_irq(mbox_irq));
  dpm_model dpm_model_inst (
    .clk(clk), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .busy_n(busy_n),
    .int_n(int_n), .far_busy_n(far_busy_n), .far_flag_wr(far_flag_wr),
    .far_flag_idx(far_flag_idx), .far_flag_bit(far_flag_bit), .far_mbox_wr(far_mbox_wr),
    .far_data(far_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: data %h, want %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic do_req(input cmd_e c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{cmd: c, addr: a, data: d};
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 4000);
    if (n >= 4000) chk1(1'b0, 1'b1);
    done = 1'b1;
  endtask : do_req

  task automatic end_sim();
    $display("compares %0d, bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Writes must never start under an active wait flag
  always @(posedge clk) if (busy_n === 1'b0 && pins.rw_n === 1'b0) wr_in_busy++;

  initial begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    far_busy_n = 1'b1;
    far_flag_wr = 1'b0;
    far_flag_bit = 1'b1;
    far_flag_idx = 3'h0;
    far_mbox_wr = 1'b0;
    far_data = 16'h0000;
    done = 1'b0;
    bad_count = 0;
    compares = 0;
    wr_in_busy = 0;
    rows[0] = '{CMD_MEM_WR, 14'h0123, 16'hA5C3, 1'b0, 16'h0000, 1'b0};
    rows[1] = '{CMD_MEM_RD, 14'h0123, 16'h0000, 1'b1, 16'hA5C3, 1'b0};
    rows[2] = '{CMD_MBOX_POST, 14'h0000, 16'h1234, 1'b0, 16'h0000, 1'b0};
    rows[3] = '{CMD_MEM_RD, 14'h3FFF, 16'h0000, 1'b1, 16'h1234, 1'b0};
    rows[4] = '{CMD_FLAG_TAKE, 14'h0003, 16'h0000, 1'b1, 16'h0000, 1'b1};
    rows[5] = '{CMD_FLAG_RD, 14'h3FFB, 16'h0000, 1'b1, 16'h0000, 1'b1};
    rows[6] = '{CMD_FLAG_GIVE, 14'h0003, 16'h0000, 1'b0, 16'h0000, 1'b0};
    rows[7] = '{CMD_FLAG_RD, 14'h0003, 16'h0000, 1'b1, 16'hFFFF, 1'b0};
    tick(5);
    sys_rst <= 1'b0;
    tick(3);
    chk1(mbox_irq, 1'b0);
    $display("test reset done");
    foreach (rows[i]) begin
      do_req(rows[i].cmd, rows[i].addr, rows[i].data);
      if (rows[i].chk) begin
        chk16(resp.data, rows[i].exp);
        chk1(resp.granted, rows[i].gr);
      end
    end
    $display("test rows done");
    far_data <= 16'hBEEF;
    far_mbox_wr <= 1'b1;
    tick(1);
    far_mbox_wr <= 1'b0;
    tick(3);
    chk1(mbox_irq, 1'b1);
    do_req(CMD_MEM_RD, 14'h3FFF, 16'h0000);
    chk16(resp.data, 16'h1234);
    chk1(mbox_irq, 1'b1);
    do_req(CMD_MBOX_FETCH, 14'h0000, 16'h0000);
    chk16(resp.data, 16'hBEEF);
    tick(3);
    chk1(mbox_irq, 1'b0);
    $display("test mailbox done");
    far_busy_n <= 1'b0;
    done = 1'b0;
    fork
      do_req(CMD_MEM_WR, 14'h0200, 16'h5A5A);
    join_none
    tick(40);
    chk1(done, 1'b0);
    far_busy_n <= 1'b1;
    wait (done === 1'b1);
    chk1(wr_in_busy == 0, 1'b1);
    do_req(CMD_MEM_RD, 14'h0200, 16'h0000);
    chk16(resp.data, 16'h5A5A);
    $display("test wait flag done");
    far_flag_idx <= 3'h5;
    far_flag_bit <= 1'b0;
    far_flag_wr <= 1'b1;
    tick(1);
    far_flag_wr <= 1'b0;
    do_req(CMD_FLAG_TAKE, 14'h0005, 16'h0000);
    chk1(resp.granted, 1'b0);
    chk16(resp.data, 16'hFFFF);
    far_flag_bit <= 1'b1;
    far_flag_wr <= 1'b1;
    tick(1);
    far_flag_wr <= 1'b0;
    tick(1);
    do_req(CMD_FLAG_RD, 14'h0005, 16'h0000);
    chk1(resp.granted, 1'b1);
    $display("test flag handover done");
    end_sim();
  end
endmodule : tb_top
